// ### common/idw_pkg.sv
// Summary of operation
// R01: Word 47 low byte gives sectors per interrupt, never above 16.
// R02: Word 49 bit 11 always one: flow-control signal supported.
// R03: Word 49 bit 10 always one: flow control can be switched by feature command.
// R04: Word 53 bits 0 to 2 one, bits 15 to 3 zero.
// R05: Fast PIO or DMA modes need word 53 bit 1 and valid words 64-70.
// R06: Word 63 bits 2 to 0 one: multiword DMA modes 0-2.
// R07: Word 64 bits 1 and 0 one: PIO modes 3 and 4.
// R08: Words 65 to 68 each report 120 ns cycle time.
// R09: Host keeps at most 32 queued tags, unique, not above word 75.
// R10: Word 76 not 0000h/FFFFh means words 77-79 valid; else ignore 76-79.
// R11: Word 76 bits 3..1 mirror speed flags; bit 0 reads zero.
// R12: Word 76 bits 15..8 mirror feature flags; bits 7..4 reserved zero.
// R13: Word 77 zero if unsupported; bits 7..4 mirror flags, rest zero.
// R14: Word 78 bits 11..1 mirror supported flags; 15..12 and 0 zero.
// R15: Word 79 present exactly when word 78 is present.
// R16: Word 79 bits 11, 9, 8..1 mirror enables; 10, 15..12, 0 zero.
// R17: Word 88 bits 5..0 one: ultra DMA modes 0 to 5.
// R18: Word 93 always reads 0000h.
// R19: Word 222 bits 15..12 hold 1h.
// R20: Other fields come from configuration inputs and track sources when read.
package idw_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_W47 = 8'h2f;
    localparam logic [7:0] ADDR_W49 = 8'h31;
    localparam logic [7:0] ADDR_W53 = 8'h35;
    localparam logic [7:0] ADDR_W63 = 8'h3f;
    localparam logic [7:0] ADDR_W64 = 8'h40;
    localparam logic [7:0] ADDR_W65 = 8'h41;
    localparam logic [7:0] ADDR_W66 = 8'h42;
    localparam logic [7:0] ADDR_W67 = 8'h43;
    localparam logic [7:0] ADDR_W68 = 8'h44;
    localparam logic [7:0] ADDR_W75 = 8'h4b;
    localparam logic [7:0] ADDR_W76 = 8'h4c;
    localparam logic [7:0] ADDR_W77 = 8'h4d;
    localparam logic [7:0] ADDR_W78 = 8'h4e;
    localparam logic [7:0] ADDR_W79 = 8'h4f;
    localparam logic [7:0] ADDR_W88 = 8'h58;
    localparam logic [7:0] ADDR_W93 = 8'h5d;
    localparam logic [7:0] ADDR_W222 = 8'hde;
    localparam logic [7:0] MAX_MULT_SECTORS = 8'h10;
    localparam logic [15:0] W49_FLOW_BITS = 16'h0c00;
    localparam logic [15:0] W53_VALID = 16'h0007;
    localparam logic [15:0] W63_MDMA = 16'h0007;
    localparam logic [15:0] W64_PIO = 16'h0003;
    localparam logic [15:0] W88_UDMA = 16'h003f;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [15:0] ONES_WORD = 16'hffff;
    localparam logic [3:0] TRANSPORT_SERIAL = 4'h1;
    localparam int CYCLE_NS = 120;
    localparam logic [15:0] CYCLE_WORD = 16'h0078;
    localparam logic [15:0] W76_MIRROR = 16'hff0e;
    localparam logic [15:0] W77_MIRROR = 16'h00f0;
    localparam logic [15:0] W78_MIRROR = 16'h0ffe;
    localparam logic [15:0] W79_MIRROR = 16'h0bfe;
    localparam int QUEUE_MAX = 32;
endpackage : idw_pkg

// ### src/idw_identify_words.sv
module idw_identify_words
    import idw_pkg::*;
#(
    parameter int SECT_LIMIT = int'(MAX_MULT_SECTORS)
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic rdEn,
    input wire logic [idw_pkg::ADDR_W-1:0] rdAddr,
    input wire logic [7:0] multSectorCfg,
    input wire logic [7:0] w47HighCfg,
    input wire logic [15:0] w49Cfg,
    input wire logic [15:0] w63Cfg,
    input wire logic [15:0] w64Cfg,
    input wire logic [15:0] w75Cfg,
    input wire logic [15:0] w88Cfg,
    input wire logic [15:0] w76Flags,
    input wire logic w77Present,
    input wire logic [15:0] w77Flags,
    input wire logic w78Present,
    input wire logic [15:0] w78Flags,
    input wire logic [15:0] w79Flags,
    input wire logic [11:0] w222LowCfg,
    output logic [idw_pkg::WORD_W-1:0] rdData,
    output logic rdValid,
    output logic mappedHit_r
);
    // --------------------------------------------------------------
    // Word builder
    // --------------------------------------------------------------
    logic [15:0] wordNxt;
    logic hitNxt;
    logic [7:0] sectClamp;
    logic [15:0] w76Word;

    function automatic logic [15:0] mirror(input logic [15:0] src, input logic [15:0] mask);
        return src & mask;
    endfunction : mirror

    localparam logic [7:0] SECT_CAP = 8'(SECT_LIMIT);

    // Anything above the cap would break the advertised interrupt limit
    if (SECT_LIMIT < 1 || SECT_LIMIT > int'(MAX_MULT_SECTORS)) begin : gSectCheck
        $error("sector limit parameter out of range");
    end

    // Clamped so a bad strap never advertises more than allowed
    assign sectClamp = (multSectorCfg > SECT_CAP) ? SECT_CAP : multSectorCfg; // see R01
    assign w76Word = mirror(w76Flags, W76_MIRROR); // see R11 see R12

    always_comb begin
        wordNxt = ZERO_WORD;
        hitNxt = 1'b1;
        case (rdAddr)
            ADDR_W47: wordNxt = {w47HighCfg, sectClamp}; // see R01 see R20
            ADDR_W49: wordNxt = (w49Cfg & ~W49_FLOW_BITS) | W49_FLOW_BITS; // see R02 see R03
            ADDR_W53: wordNxt = W53_VALID; // see R04 see R05
            ADDR_W63: wordNxt = w63Cfg | W63_MDMA; // see R06
            ADDR_W64: wordNxt = w64Cfg | W64_PIO; // see R07 see R05
            ADDR_W65: wordNxt = CYCLE_WORD; // see R08
            ADDR_W66: wordNxt = CYCLE_WORD; // see R08
            ADDR_W67: wordNxt = CYCLE_WORD; // see R08
            ADDR_W68: wordNxt = CYCLE_WORD; // see R08
            ADDR_W75: wordNxt = w75Cfg; // see R20
            ADDR_W76: wordNxt = w76Word; // see R10
            ADDR_W77: wordNxt = w77Present ? mirror(w77Flags, W77_MIRROR) : ZERO_WORD; // see R13
            ADDR_W78: wordNxt = w78Present ? mirror(w78Flags, W78_MIRROR) : ZERO_WORD; // see R14
            // Word 79 follows word 78 presence
            ADDR_W79: wordNxt = w78Present ? mirror(w79Flags, W79_MIRROR) : ZERO_WORD; // see R15 see R16
            ADDR_W88: wordNxt = w88Cfg | W88_UDMA; // see R17
            ADDR_W93: wordNxt = ZERO_WORD; // see R18
            ADDR_W222: wordNxt = {TRANSPORT_SERIAL, w222LowCfg}; // see R19
            default: hitNxt = 1'b0;
        endcase
    end

    // --------------------------------------------------------------
    // Output registers
    // --------------------------------------------------------------
    idw_word_reg #(.WIDTH(WORD_W)) uWord (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .loadEn(rdEn),
        .dataIn(wordNxt),
        .dataOut(rdData)
    );

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdEn;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mappedHit_r <= 1'b0;
        end else if (rdEn) begin
            mappedHit_r <= hitNxt;
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sect_limit_a: assert property (rdEn && rdAddr == ADDR_W47 |=> rdData[7:0] <= MAX_MULT_SECTORS) // see R01
        else $error("sector limit exceeded");
    flow_bits_a: assert property (rdEn && rdAddr == ADDR_W49 |=> rdData[11] && rdData[10]) // see R02
        else $error("flow bits not set");
    valid_word_a: assert property (rdEn && rdAddr == ADDR_W53 |=> rdData == W53_VALID) // see R04
        else $error("validity word wrong");
    mdma_bits_a: assert property (rdEn && rdAddr == ADDR_W63 |=> rdData[2:0] == 3'h7) // see R06
        else $error("dma mode bits wrong");
    pio_bits_a: assert property (rdEn && rdAddr == ADDR_W64 |=> rdData[1:0] == 2'h3) // see R07
        else $error("pio mode bits wrong");
    cycle_time_a: assert property (rdEn && rdAddr >= ADDR_W65 && rdAddr <= ADDR_W68
        |=> rdData == 16'(CYCLE_NS)) // see R08
        else $error("cycle time wrong");
    w76_reserved_a: assert property (rdEn && rdAddr == ADDR_W76 |=> rdData[7:4] == 4'h0 && !rdData[0]) // see R11
        else $error("word 76 reserved bits set");
    w79_follow_a: assert property (rdEn && rdAddr == ADDR_W79 && !w78Present |=> rdData == ZERO_WORD) // see R15
        else $error("word 79 without word 78");
    w79_reserved_a: assert property (rdEn && rdAddr == ADDR_W79 |=> rdData[10] == 1'b0 && rdData[15:12] == 4'h0) // see R16
        else $error("word 79 reserved set");
    udma_bits_a: assert property (rdEn && rdAddr == ADDR_W88 |=> rdData[5:0] == 6'h3f) // see R17
        else $error("udma bits wrong");
    hw_test_a: assert property (rdEn && rdAddr == ADDR_W93 |=> rdData == ZERO_WORD) // see R18
        else $error("word 93 nonzero");
    revision_a: assert property (rdEn && rdAddr == ADDR_W222 |=> rdData[15:12] == TRANSPORT_SERIAL) // see R19
        else $error("transport type wrong");
    track_src_a: assert property (rdEn && rdAddr == ADDR_W75 |=> rdData == $past(w75Cfg)) // see R20
        else $error("queue depth not tracked");

    // --------------------------------------------------------------
    // Protocol checks
    // --------------------------------------------------------------
    // Map decode kept apart from the case so checks do not copy it
    function automatic logic isMapped(input logic [7:0] addr);
        case (addr)
            ADDR_W47, ADDR_W49, ADDR_W53, ADDR_W63, ADDR_W64: return 1'b1;
            ADDR_W65, ADDR_W66, ADDR_W67, ADDR_W68, ADDR_W75: return 1'b1;
            ADDR_W76, ADDR_W77, ADDR_W78, ADDR_W79, ADDR_W88: return 1'b1;
            ADDR_W93, ADDR_W222: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : isMapped

    sequence readAt(logic [7:0] a);
        rdEn && rdAddr == a;
    endsequence

    sequence twoReads(logic [7:0] a, logic [7:0] b);
        readAt(a) ##1 readAt(b);
    endsequence

    valid_pulse_a: assert property ( // see R20
        rdEn |=> rdValid)
        else $error("read not answered");

    valid_idle_a: assert property ( // see R20
        !rdEn |=> !rdValid)
        else $error("answer without read");

    data_hold_a: assert property ( // see R20
        !rdEn |=> $stable(rdData))
        else $error("read data moved without read");

    hit_hold_a: assert property ( // see R20
        !rdEn |=> $stable(mappedHit_r))
        else $error("hit flag moved without read");

    mapped_hit_a: assert property ( // see R20
        rdEn && isMapped(rdAddr) |=> mappedHit_r)
        else $error("mapped word not flagged");

    unmapped_zero_a: assert property ( // see R20
        rdEn && !isMapped(rdAddr) |=> rdData == ZERO_WORD && !mappedHit_r)
        else $error("unmapped word not zero");

    // --------------------------------------------------------------
    // Field checks
    // --------------------------------------------------------------
    sect_exact_a: assert property ( // see R01
        readAt(ADDR_W47) && multSectorCfg <= SECT_CAP |=> rdData[7:0] == $past(multSectorCfg))
        else $error("sector count not passed");

    sect_clamp_a: assert property ( // see R01
        readAt(ADDR_W47) && multSectorCfg > SECT_CAP |=> rdData[7:0] == SECT_CAP)
        else $error("sector count not clamped");

    w47_high_a: assert property ( // see R20
        readAt(ADDR_W47) |=> rdData[15:8] == $past(w47HighCfg))
        else $error("word 47 high byte wrong");

    flow_switch_a: assert property ( // see R03
        readAt(ADDR_W49) |=> rdData[10])
        else $error("flow switch bit clear");

    w49_pass_a: assert property ( // see R20
        readAt(ADDR_W49) |=> rdData[15:12] == $past(w49Cfg[15:12]) && rdData[9:0] == $past(w49Cfg[9:0]))
        else $error("word 49 config bits wrong");

    valid_fast_a: assert property ( // see R05
        readAt(ADDR_W53) |=> rdData[1])
        else $error("fast mode words not valid");

    w53_reserved_a: assert property ( // see R04
        readAt(ADDR_W53) |=> rdData[15:3] == 13'h0000 && rdData[0])
        else $error("word 53 reserved bits wrong");

    w63_pass_a: assert property ( // see R20
        readAt(ADDR_W63) |=> rdData[15:3] == $past(w63Cfg[15:3]))
        else $error("word 63 config bits wrong");

    w64_pass_a: assert property ( // see R20
        readAt(ADDR_W64) |=> rdData[15:2] == $past(w64Cfg[15:2]))
        else $error("word 64 config bits wrong");

    w88_pass_a: assert property ( // see R20
        readAt(ADDR_W88) |=> rdData[15:6] == $past(w88Cfg[15:6]))
        else $error("word 88 config bits wrong");

    w222_low_a: assert property ( // see R20
        readAt(ADDR_W222) |=> rdData[11:0] == $past(w222LowCfg))
        else $error("word 222 low bits wrong");

    // One check per cycle-time word
    localparam int N_CYCLE_WORDS = int'(ADDR_W68 - ADDR_W65) + 1;
    for (genvar k = 0; k < N_CYCLE_WORDS; k++) begin : gCycle
        cycle_word_a: assert property ( // see R08
            readAt(ADDR_W65 + 8'(k)) |=> rdData == CYCLE_WORD)
            else $error("cycle word wrong");
    end

    // --------------------------------------------------------------
    // Mirror checks
    // --------------------------------------------------------------
    w76_mirror_a: assert property ( // see R12
        readAt(ADDR_W76) |=> rdData[15:8] == $past(w76Flags[15:8]) && rdData[7:4] == 4'h0)
        else $error("word 76 feature bits wrong");

    w76_speed_a: assert property ( // see R11
        readAt(ADDR_W76) |=> rdData[3:1] == $past(w76Flags[3:1]))
        else $error("word 76 speed bits wrong");

    w76_comply_a: assert property ( // see R10
        readAt(ADDR_W76) |=> rdData != ONES_WORD)
        else $error("word 76 reads all ones");

    w77_absent_a: assert property ( // see R13
        readAt(ADDR_W77) && !w77Present |=> rdData == ZERO_WORD)
        else $error("absent word 77 not zero");

    w77_mirror_a: assert property ( // see R13
        readAt(ADDR_W77) && w77Present |=> rdData[7:4] == $past(w77Flags[7:4]) && rdData[3:0] == 4'h0)
        else $error("word 77 flags wrong");

    w77_reserved_a: assert property ( // see R13
        readAt(ADDR_W77) |=> rdData[15:8] == 8'h00 && !rdData[0])
        else $error("word 77 reserved bits set");

    w78_absent_a: assert property ( // see R14
        readAt(ADDR_W78) && !w78Present |=> rdData == ZERO_WORD)
        else $error("absent word 78 not zero");

    w78_mirror_a: assert property ( // see R14
        readAt(ADDR_W78) && w78Present |=> rdData[11:1] == $past(w78Flags[11:1]))
        else $error("word 78 flags wrong");

    w78_reserved_a: assert property ( // see R14
        readAt(ADDR_W78) |=> rdData[15:12] == 4'h0 && !rdData[0])
        else $error("word 78 reserved bits set");

    w79_mirror_a: assert property ( // see R16
        readAt(ADDR_W79) && w78Present |=> rdData[11] == $past(w79Flags[11])
        && rdData[9:1] == $past(w79Flags[9:1]) && !rdData[0])
        else $error("word 79 flags wrong");

    // --------------------------------------------------------------
    // Back-to-back checks
    // --------------------------------------------------------------
    w79_pair_a: assert property ( // see R15
        twoReads(ADDR_W78, ADDR_W79) ##0 !w78Present |=> rdData == ZERO_WORD)
        else $error("word 79 shown after absent word 78");

    hw_after_valid_a: assert property ( // see R18
        twoReads(ADDR_W53, ADDR_W93) |=> rdData == ZERO_WORD)
        else $error("word 93 nonzero in burst");

    valid_after_hw_a: assert property ( // see R04
        twoReads(ADDR_W93, ADDR_W53) |=> rdData == W53_VALID)
        else $error("word 53 wrong in burst");

    flow_pair_a: assert property ( // see R02
        twoReads(ADDR_W47, ADDR_W49) |=> rdData[11])
        else $error("flow bit clear in burst");

    flow_switch_pair_a: assert property ( // see R03
        twoReads(ADDR_W47, ADDR_W49) |=> rdData[10])
        else $error("flow switch bit clear in burst");

    revision_pair_a: assert property ( // see R19
        twoReads(ADDR_W93, ADDR_W222) |=> rdData[15:12] == TRANSPORT_SERIAL)
        else $error("transport type wrong in burst");
endmodule : idw_identify_words

// ### src/idw_word_reg.sv
// Registered word stage; read data comes from a flip-flop.
module idw_word_reg #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic loadEn,
    input wire logic [WIDTH-1:0] dataIn,
    output logic [WIDTH-1:0] dataOut
);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dataOut <= '0;
        end else if (loadEn) begin
            dataOut <= dataIn;
        end
    end
endmodule : idw_word_reg

// ### testbench/idw_host_model.sv
module idw_host_model
    import idw_pkg::*;
(
    input wire logic sys_clk,
    output logic rdEn,
    output logic [idw_pkg::ADDR_W-1:0] rdAddr,
    input wire logic [idw_pkg::WORD_W-1:0] rdData,
    input wire logic rdValid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rdEn = 1'b0;
        rdAddr = 8'h00;
    end
    // One request at a time, so no queue tag is ever in use twice
    task automatic read_word(input logic [7:0] addr, output logic [15:0] data);
        @(negedge sys_clk);
        rdEn = 1'b1;
        rdAddr = addr;
        @(negedge sys_clk);
        data = rdData;
        rdEn = 1'b0;
        // Released address inverts, so a stale value never passes
        rdAddr = ~addr;
    endtask : read_word
    // Two reads on consecutive edges; strobe stays up between them
    task automatic read_pair(input logic [7:0] addrA, input logic [7:0] addrB, output logic [15:0] dataA,
        output logic [15:0] dataB);
        @(negedge sys_clk);
        rdEn = 1'b1;
        rdAddr = addrA;
        @(negedge sys_clk);
        dataA = rdData;
        rdAddr = addrB;
        @(negedge sys_clk);
        dataB = rdData;
        rdEn = 1'b0;
        rdAddr = ~addrB;
    endtask : read_pair
endmodule : idw_host_model

// ### testbench/tb.sv
module tb
    import idw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic rdEn, rdValid, mappedHit_r;
    logic w77Present = 1'b1;
    logic w78Present = 1'b1;
    logic [7:0] rdAddr;
    logic [7:0] multSectorCfg = 8'h20;
    logic [7:0] w47HighCfg = 8'h5a;
    logic [15:0] rdData, got;
    logic [15:0] w49Cfg = 16'h1234;
    logic [15:0] w63Cfg = 16'h0400;
    logic [15:0] w64Cfg = 16'h0000;
    logic [15:0] w75Cfg = 16'h001f;
    logic [15:0] w88Cfg = 16'h0100;
    logic [15:0] w76Flags = 16'ha5f3;
    logic [15:0] w77Flags = 16'hffff;
    logic [15:0] w78Flags = 16'hffff;
    logic [15:0] w79Flags = 16'hffff;
    logic [11:0] w222LowCfg = 12'habc;
    int failures = 0;
    int nTests = 0;
    localparam logic [7:0] FA [6] = '{ADDR_W53, ADDR_W65, ADDR_W66, ADDR_W67, ADDR_W68, ADDR_W93};
    localparam logic [15:0] FV [6] = '{16'h0007, 16'h0078, 16'h0078, 16'h0078, 16'h0078, 16'h0000};
    always #50 sys_clk = ~sys_clk;
    idw_identify_words idw_identify_words_i (.sys_clk, .rst_b, .rdEn, .rdAddr, .multSectorCfg, .w47HighCfg,
        .w49Cfg, .w63Cfg, .w64Cfg, .w75Cfg, .w88Cfg, .w76Flags, .w77Present, .w77Flags, .w78Present,
        .w78Flags, .w79Flags, .w222LowCfg, .rdData, .rdValid, .mappedHit_r);
    idw_host_model idw_host_model_i (.sys_clk, .rdEn, .rdAddr, .rdData, .rdValid);
    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nTests++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd(input logic [7:0] addr, input logic [15:0] exp, input logic hit);
        idw_host_model_i.read_word(addr, got);
        check(got, exp);
        check({14'h0000, rdValid, mappedHit_r}, {14'h0000, 1'b1, hit});
        @(negedge sys_clk);
        check({15'h0000, rdValid}, 16'h0000);
        check(rdData, exp);
    endtask : rd
    task automatic rd2(input logic [7:0] a, input logic [7:0] b, input logic [15:0] ea, input logic [15:0] eb);
        logic [15:0] got2;
        idw_host_model_i.read_pair(a, b, got, got2);
        check(got, ea);
        check(got2, eb);
        check({15'h0000, rdValid}, 16'h0001);
    endtask : rd2
    task automatic give_verdict();
        if (failures == 0 && nTests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        failures++;
        give_verdict();
    end
    initial begin
        repeat (12) @(negedge sys_clk);
        rst_b = 1'b1;
        foreach (FA[i]) rd(FA[i], FV[i], 1'b1);
        rd(ADDR_W47, 16'h5a10, 1'b1);
        multSectorCfg = 8'h0c;
        rd(ADDR_W47, 16'h5a0c, 1'b1);
        rd(ADDR_W49, 16'h1e34, 1'b1);
        rd(ADDR_W63, 16'h0407, 1'b1);
        rd(ADDR_W64, 16'h0003, 1'b1);
        rd(ADDR_W88, 16'h013f, 1'b1);
        rd(ADDR_W75, 16'h001f, 1'b1);
        w75Cfg = 16'h000f;
        rd(ADDR_W75, 16'h000f, 1'b1);
        rd(ADDR_W76, 16'ha502, 1'b1);
        rd(ADDR_W77, 16'h00f0, 1'b1);
        rd(ADDR_W78, 16'h0ffe, 1'b1);
        rd(ADDR_W79, 16'h0bfe, 1'b1);
        rd2(ADDR_W53, ADDR_W93, 16'h0007, 16'h0000);
        rd2(ADDR_W93, ADDR_W53, 16'h0000, 16'h0007);
        rd2(ADDR_W47, ADDR_W49, 16'h5a0c, 16'h1e34);
        rd2(ADDR_W93, ADDR_W222, 16'h0000, 16'h1abc);
        w77Present = 1'b0;
        w78Present = 1'b0;
        rd(ADDR_W77, 16'h0000, 1'b1);
        rd(ADDR_W78, 16'h0000, 1'b1);
        rd(ADDR_W79, 16'h0000, 1'b1);
        rd2(ADDR_W78, ADDR_W79, 16'h0000, 16'h0000);
        rd(ADDR_W222, 16'h1abc, 1'b1);
        rd(8'h30, 16'h0000, 1'b0);
        give_verdict();
    end
endmodule : tb
